// ### adcc_pkg.sv
// What this block does
// [R1] reference comes from analog supply, external reference pin or gain amp output
// [R2] reference code 00 supply, 01 external pin, 1x gain amp output
// [R3] gain amp offers four gains by gain_sel, works only while enabled
// [R4] gain codes 00 x1, 01 x1.667, 10 x2.5, 11 x3.333
// [R5] gain amp input is external ref pin or internal bandgap
// [R6] input select 0 picks external pin, 1 picks bandgap
// [R7] internal reference selected disconnects external reference pins automatically
// [R8] software enables bandgap and waits start-up before selecting it
// [R9] analog pin function disables original function and overrides port direction
// [R10] pull-high disconnected while pin is analog input
// [R11] source codes 0000, 0100, 11xx route an external channel
// [R12] channel field picks one of sixteen pins, 0 to 15
// [R13] codes 0001/0010/0011 route supply, supply/2, supply/4
// [R14] codes 0101/0110/0111 route amp output, /2, /4
// [R15] codes 10xx connect converter input to ground
// [R16] internal signal routed disconnects every external channel
// [R17] start bit low-high-low pulse begins a conversion
// [R18] busy reads 1 from start until completion, then hardware clears it
// [R19] completion sets interrupt request flag and raises interrupt if enabled
// [R20] with interrupt off software polls busy until cleared
// [R21] converter clock is system clock divided by 2^sel, 1 to 128
// [R22] software keeps converter clock period between 0.5us and 10us
// [R23] converter powered only while enable bit is high
// [R24] software waits settling delay after enable before first start
// [R25] software should clear enable when converter is unused
// [R26] conversion lasts 16 converter clocks: 4 sampling then 12 converting
// [R27] enable low ignores start pulses and keeps busy cleared
package adcc_pkg;
  localparam logic [3:0] ADDR_CTRL0  = 4'h0;
  localparam logic [3:0] ADDR_CTRL1  = 4'h4;
  localparam logic [3:0] ADDR_CTRL2  = 4'h8;
  localparam logic [3:0] ADDR_BANDG  = 4'hC;
  localparam logic [31:0] REG_RESET  = 32'h0;
  // ctrl0 fields
  localparam int CHAN_LSB   = 0;
  localparam int BUSY_BIT   = 4;
  localparam int ENABLE_BIT = 5;
  localparam int START_BIT  = 6;
  localparam int IRQEN_BIT  = 7;
  localparam int IRQF_BIT   = 8;
  // ctrl1 fields
  localparam int DIV_LSB    = 0;
  localparam int SRC_LSB    = 4;
  // ctrl2 fields, then the bandgap register field
  localparam int GAIN_LSB   = 0;
  localparam int REFSEL_LSB = 2;
  localparam int AMPIN_BIT  = 4;
  localparam int AMPEN_BIT  = 7;
  localparam int BGEN_BIT   = 0;
  localparam logic [4:0] SAMPLE_CLKS = 5'h04;
  localparam logic [4:0] CONV_CLKS   = 5'h0C;
  localparam logic [4:0] TOTAL_CLKS  = 5'h10;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    REF_SUPPLY = 2'b00,
    REF_PIN    = 2'b01,
    REF_AMP    = 2'b10
  } adcc_ref_t;
  typedef enum logic [3:0] {
    SRC_NONE   = 4'h0,
    SRC_EXT    = 4'h1,
    SRC_SUP    = 4'h2,
    SRC_SUP2   = 4'h3,
    SRC_SUP4   = 4'h4,
    SRC_AMP    = 4'h5,
    SRC_AMP2   = 4'h6,
    SRC_AMP4   = 4'h7,
    SRC_GND    = 4'h8
  } adcc_src_t;
endpackage

// ### adcc_conv_if.sv
`timescale 1ns/1ps
interface adcc_conv_if;
  logic       enable;
  logic [2:0] divSel;
  logic       startPulse;
  logic       busy;
  logic       done;
  logic       sampling;
  logic       adcClkEn;
  modport ctrl (output enable, output divSel, output startPulse,
                input busy, input done, input sampling, input adcClkEn);
  modport seq  (input enable, input divSel, input startPulse,
                output busy, output done, output sampling, output adcClkEn);
endinterface

// ### adcc_conv_seq.sv
`timescale 1ns/1ps
module adcc_conv_seq (
  input wire logic clk,
  input wire logic rst,
  adcc_conv_if.seq cv
);
  import adcc_pkg::*;
  logic [6:0] divCnt;
  logic [4:0] phaseCnt;
  logic       busyQ;
  logic       adcTick;

  // tick at the end of each divided period
  function automatic logic divEnd(input logic [6:0] cnt, input logic [2:0] sel);
    logic [6:0] mask;
    mask = 7'((8'h01 << sel) - 8'h01);
    divEnd = (cnt & mask) == mask;
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt <= 7'h00;
    end else if (!cv.enable) begin
      divCnt <= 7'h00;
    end else if (!busyQ && cv.startPulse) begin
      // restart so a conversion spans whole converter periods only
      divCnt <= 7'h00; // [R26]
    end else begin
      divCnt <= divCnt + 7'h01; // [R21]
    end
  end
  assign adcTick = cv.enable && divEnd(divCnt, cv.divSel); // [R21]
  assign cv.adcClkEn = adcTick;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyQ    <= 1'b0;
      phaseCnt <= 5'h00;
    end else if (!cv.enable) begin
      busyQ    <= 1'b0; // [R27]
      phaseCnt <= 5'h00;
    end else if (!busyQ && cv.startPulse) begin
      busyQ    <= 1'b1; // [R17] [R18]
      phaseCnt <= 5'h00;
    end else if (busyQ && adcTick) begin
      if (phaseCnt == TOTAL_CLKS - 5'h01) begin
        busyQ    <= 1'b0; // [R26]
        phaseCnt <= 5'h00;
      end else begin
        phaseCnt <= phaseCnt + 5'h01;
      end
    end
  end
  assign cv.busy     = busyQ;
  assign cv.done     = busyQ && adcTick && phaseCnt == TOTAL_CLKS - 5'h01; // [R19]
  assign cv.sampling = busyQ && phaseCnt < SAMPLE_CLKS; // [R26]

  a_busy_ends_done: assert property (@(posedge clk) disable iff (rst) // [R18]
    cv.done |=> !cv.busy)
    else $error("busy stays after done");
  a_off_no_busy: assert property (@(posedge clk) disable iff (rst) // [R27]
    !cv.enable |=> !cv.busy)
    else $error("busy while disabled");
  a_start_sets_busy: assert property (@(posedge clk) disable iff (rst) // [R17]
    cv.enable && cv.startPulse && !cv.busy |=> cv.busy)
    else $error("start lost");
  a_undiv_length: assert property (@(posedge clk) disable iff (rst) // [R26]
    $rose(cv.busy) && cv.divSel == 3'h0 && cv.enable
      |-> cv.busy [*8] ##1 cv.busy [*8] ##1 !cv.busy)
    else $error("conversion length wrong");
endmodule

// ### adcc_ctrl_top.sv
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module adcc_ctrl_top (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [3:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output wire logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output wire logic                   s_axi_wready,
  output      logic [1:0]             s_axi_bresp,
  output      logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [3:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output wire logic                   s_axi_arready,
  output      logic [31:0]            s_axi_rdata,
  output      logic [1:0]             s_axi_rresp,
  output      logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic [15:0]            pin_func_sel_hi,
  input  wire logic [15:0]            pin_func_sel_lo,
  input  wire logic [15:0]            pinDirOut,
  input  wire logic [15:0]            pinPullUpEn,
  output      logic [15:0]            pinDigitalEn,
  output      logic [15:0]            pinDirEff,
  output      logic [15:0]            pinPullUpEff,
  output      logic [15:0]            analogChanConnect,
  output      adcc_pkg::adcc_src_t    convInputRoute,
  output      adcc_pkg::adcc_ref_t    convRefRoute,
  output      logic                   refPinConnect,
  output      logic                   ampRefPinConnect,
  output      logic                   ampBandgapConnect,
  output      logic                   gain_amp_enable,
  output      logic [1:0]             gain_sel,
  output      logic                   bandgap_enable,
  output      logic                   converterPower,
  output      logic                   convSampling,
  output      logic                   convClkEn,
  output      logic                   convDone,
  output      logic                   convIrq
);
  import adcc_pkg::*;
  adcc_conv_if cv ();

  logic [31:0] ctrl0;
  logic [31:0] ctrl1;
  logic [31:0] ctrl2;
  logic [31:0] bandg;
  logic        irqFlag;
  logic        startQ;
  logic [3:0]  awAddrQ;
  logic        awHeld;
  logic [31:0] wDataQ;
  logic [3:0]  wStrbQ;
  logic        wHeld;
  logic        doWrite;
  logic [3:0]  ext_channel_sel;
  logic [3:0]  input_source_sel;
  logic [1:0]  ref_source_sel;
  logic        gain_amp_input_sel;
  logic        converter_enable;
  logic        extRouted;
  wire  [15:0] pinAnalog;

  assign ext_channel_sel    = ctrl0[CHAN_LSB +: 4];
  assign converter_enable   = ctrl0[ENABLE_BIT];
  assign input_source_sel   = ctrl1[SRC_LSB +: 4];
  assign ref_source_sel     = ctrl2[REFSEL_LSB +: 2];
  assign gain_amp_input_sel = ctrl2[AMPIN_BIT];
  assign extRouted          = srcDecode(input_source_sel) == SRC_EXT; // [R11] [R16]

  // source code decode, used by routing and channel gating
  function automatic adcc_src_t srcDecode(input logic [3:0] code);
    case (code) inside
      4'b0000, 4'b0100, 4'b11??: srcDecode = SRC_EXT; // [R11]
      4'b0001: srcDecode = SRC_SUP; // [R13]
      4'b0010: srcDecode = SRC_SUP2;
      4'b0011: srcDecode = SRC_SUP4;
      4'b0101: srcDecode = SRC_AMP; // [R14]
      4'b0110: srcDecode = SRC_AMP2;
      4'b0111: srcDecode = SRC_AMP4;
      4'b10??: srcDecode = SRC_GND; // [R15]
      default: srcDecode = SRC_GND;
    endcase
  endfunction

  // register bus: write address and data may arrive in either order
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign doWrite       = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld  <= 1'b0;
      awAddrQ <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld  <= 1'b1;
      awAddrQ <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld  <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wHeld  <= 1'b0;
      wDataQ <= 32'h0;
      wStrbQ <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld  <= 1'b1;
      wDataQ <= s_axi_wdata;
      wStrbQ <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld  <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddrQ == ADDR_CTRL0 || awAddrQ == ADDR_CTRL1 ||
                       awAddrQ == ADDR_CTRL2 || awAddrQ == ADDR_BANDG)
                      ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control registers; busy and irq flag are hardware bits kept apart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl0 <= REG_RESET;
      ctrl1 <= REG_RESET;
      ctrl2 <= REG_RESET;
      bandg <= REG_RESET;
    end else if (doWrite && wStrbQ[0]) begin
      case (awAddrQ)
        ADDR_CTRL0: ctrl0 <= {24'h0, wDataQ[7:6], wDataQ[ENABLE_BIT], 1'b0, wDataQ[3:0]};
        ADDR_CTRL1: ctrl1 <= {24'h0, wDataQ[7:4], 1'b0, wDataQ[2:0]};
        ADDR_CTRL2: ctrl2 <= {24'h0, wDataQ[7], 2'b00, wDataQ[4:0]};
        ADDR_BANDG: bandg <= {31'h0, wDataQ[BGEN_BIT]};
        default: ;
      endcase
    end
  end

  // start fires on the falling edge of the written start bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      startQ <= 1'b0;
    end else begin
      startQ <= ctrl0[START_BIT];
    end
  end
  assign cv.startPulse = startQ && !ctrl0[START_BIT] && converter_enable; // [R17] [R27]
  assign cv.enable     = converter_enable;
  assign cv.divSel     = ctrl1[DIV_LSB +: 3];

  // sequencer owns the divider, busy and done timing
  adcc_conv_seq u_seq (
    .clk (clk),
    .rst (rst),
    .cv  (cv)
  );

  // interrupt request flag: set wins over a software clear (write 1 to clear)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqFlag <= 1'b0;
    end else if (cv.done) begin
      irqFlag <= 1'b1; // [R19]
    end else if (doWrite && wStrbQ[1] && awAddrQ == ADDR_CTRL0 && wDataQ[IRQF_BIT]) begin
      irqFlag <= 1'b0;
    end
  end

  // read channel
  // busy is read live from the sequencer, software cannot write it
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL0: s_axi_rdata <= {23'h0, irqFlag, ctrl0[7:5], cv.busy, ctrl0[3:0]}; // [R18]
        ADDR_CTRL1: s_axi_rdata <= ctrl1;
        ADDR_CTRL2: s_axi_rdata <= ctrl2;
        ADDR_BANDG: s_axi_rdata <= bandg;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // analog steering, registered so the switches never glitch
  // a new setting reaches the switches one clock after the write lands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      convInputRoute    <= SRC_NONE;
      convRefRoute      <= REF_SUPPLY;
      refPinConnect     <= 1'b0;
      ampRefPinConnect  <= 1'b0;
      ampBandgapConnect <= 1'b0;
      analogChanConnect <= 16'h0;
      gain_amp_enable   <= 1'b0;
      gain_sel          <= 2'h0;
      bandgap_enable    <= 1'b0;
      converterPower    <= 1'b0;
      convIrq           <= 1'b0;
    end else begin
      convInputRoute    <= srcDecode(input_source_sel); // [R11] [R13] [R14] [R15]
      convRefRoute      <= ref_source_sel[1] ? REF_AMP
                           : (ref_source_sel[0] ? REF_PIN : REF_SUPPLY); // [R1] [R2]
      refPinConnect     <= ref_source_sel == 2'b01; // [R7]
      ampRefPinConnect  <= ctrl2[AMPEN_BIT] && !gain_amp_input_sel; // [R5] [R6] [R7]
      ampBandgapConnect <= ctrl2[AMPEN_BIT] && gain_amp_input_sel; // [R6]
      analogChanConnect <= extRouted ? 16'(17'h1 << ext_channel_sel) : 16'h0; // [R12] [R16]
      gain_amp_enable   <= ctrl2[AMPEN_BIT]; // [R3]
      gain_sel          <= ctrl2[AMPEN_BIT] ? ctrl2[GAIN_LSB +: 2] : 2'h0; // [R3] [R4]
      bandgap_enable    <= bandg[BGEN_BIT];
      converterPower    <= converter_enable; // [R23]
      convIrq           <= irqFlag && ctrl0[IRQEN_BIT]; // [R19]
    end
  end

  // pin-function override for analog pins (both select bits set)
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_pin
      assign pinAnalog[gi] = pin_func_sel_hi[gi] && pin_func_sel_lo[gi]; // [R9]
    end
  endgenerate

  // pull-ups cut as well, a resistor on an analog pin would load the source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinDigitalEn <= 16'hFFFF;
      pinDirEff    <= 16'h0000;
      pinPullUpEff <= 16'h0000;
    end else begin
      pinDigitalEn <= ~pinAnalog; // [R9]
      pinDirEff    <= pinDirOut & ~pinAnalog; // [R9]
      pinPullUpEff <= pinPullUpEn & ~pinAnalog; // [R10]
    end
  end

  assign convSampling = cv.sampling;
  assign convClkEn    = cv.adcClkEn;
  assign convDone     = cv.done;

  // flag and routing checks
  a_irq_after_done: assert property (@(posedge clk) disable iff (rst) // [R19]
    cv.done |=> irqFlag)
    else $error("flag not set on done");
  a_irq_masked: assert property (@(posedge clk) disable iff (rst) // [R19]
    !ctrl0[IRQEN_BIT] |=> !convIrq)
    else $error("interrupt while masked");
  a_int_no_ext: assert property (@(posedge clk) disable iff (rst) // [R16]
    !extRouted |=> analogChanConnect == 16'h0)
    else $error("external channel joined");
  a_chan_onehot: assert property (@(posedge clk) disable iff (rst) // [R12]
    $onehot0(analogChanConnect))
    else $error("two channels joined");
  a_gnd_route: assert property (@(posedge clk) disable iff (rst) // [R15]
    input_source_sel[3:2] == 2'b10 |=> convInputRoute == SRC_GND)
    else $error("ground not routed");
  a_ref_pin_off: assert property (@(posedge clk) disable iff (rst) // [R7]
    convRefRoute != REF_PIN |-> !refPinConnect)
    else $error("reference pin left on");
  a_amp_off_open: assert property (@(posedge clk) disable iff (rst) // [R3]
    !gain_amp_enable |-> !ampRefPinConnect && !ampBandgapConnect)
    else $error("amp input on while off");
  a_amp_in_single: assert property (@(posedge clk) disable iff (rst) // [R5]
    !(ampRefPinConnect && ampBandgapConnect))
    else $error("both amp inputs on");

  // pin and power checks
  a_pull_off: assert property (@(posedge clk) disable iff (rst) // [R10]
    pinAnalog != 16'h0 |=> (pinPullUpEff & $past(pinAnalog)) == 16'h0)
    else $error("pull-up on analog pin");
  a_digital_off: assert property (@(posedge clk) disable iff (rst) // [R9]
    pinAnalog != 16'h0 |=> (pinDigitalEn & $past(pinAnalog)) == 16'h0)
    else $error("digital function on analog pin");
  a_dir_override: assert property (@(posedge clk) disable iff (rst) // [R9]
    pinAnalog != 16'h0 |=> (pinDirEff & $past(pinAnalog)) == 16'h0)
    else $error("output driver on analog pin");
  a_power_follows: assert property (@(posedge clk) disable iff (rst) // [R23]
    $fell(converter_enable) |=> !converterPower)
    else $error("power stays on");
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  import adcc_pkg::*;
  logic        clk, rst;
  logic [3:0]  awAddr, wStrb, arAddr;
  logic [31:0] wData, rData;
  logic        awValid, wValid, bReady, arValid, rReady;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic [1:0]  bResp, rResp;
  logic [15:0] selHi, selLo, dirOut, pullEn;
  logic [15:0] digEn, dirEff, pullEff, chanConn;
  adcc_src_t   inRoute;
  adcc_ref_t   refRoute;
  logic        refPin, ampPin, ampBg, ampEn, bgEn, power, sampling, clkEn, done, irq;
  logic [1:0]  gainOut;
  int          err_total, check_count;
  localparam logic [31:0] EN = 32'h1 << ENABLE_BIT;
  localparam logic [31:0] IE = 32'h1 << IRQEN_BIT;

  adcc_ctrl_top i_adcc_ctrl_top (.clk(clk), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .pin_func_sel_hi(selHi),
    .pin_func_sel_lo(selLo), .pinDirOut(dirOut), .pinPullUpEn(pullEn),
    .pinDigitalEn(digEn), .pinDirEff(dirEff), .pinPullUpEff(pullEff),
    .analogChanConnect(chanConn), .convInputRoute(inRoute), .convRefRoute(refRoute),
    .refPinConnect(refPin), .ampRefPinConnect(ampPin), .ampBandgapConnect(ampBg),
    .gain_amp_enable(ampEn), .gain_sel(gainOut), .bandgap_enable(bgEn),
    .converterPower(power), .convSampling(sampling), .convClkEn(clkEn),
    .convDone(done), .convIrq(irq));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic timeout();
    err_total++;
    summarize();
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    awAddr <= a;
    awValid <= 1'b1;
    wData <= d;
    wStrb <= s;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid === 1'b1) break;
    end
    bReady <= 1'b0;
    if (n == 50) timeout();
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid === 1'b1) break;
    end
    d = rData;
    rReady <= 1'b0;
    if (n == 50) timeout();
  endtask

  // registered outputs need a couple of edges to follow a write
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  task automatic t_routes();
    logic [3:0]  c;
    logic [31:0] x;
    adcc_src_t   e;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      case (c)
        4'h1: e = SRC_SUP;
        4'h2: e = SRC_SUP2;
        4'h3: e = SRC_SUP4;
        4'h5: e = SRC_AMP;
        4'h6: e = SRC_AMP2;
        4'h7: e = SRC_AMP4;
        4'h8, 4'h9, 4'hA, 4'hB: e = SRC_GND;
        default: e = SRC_EXT;
      endcase
      wr(ADDR_CTRL0, 32'(15 - i), 4'h1);
      wr(ADDR_CTRL1, 32'(c) << SRC_LSB, 4'h1);
      settle();
      check(32'(inRoute), 32'(e), "input route");
      x = (e == SRC_EXT) ? 32'h1 << (15 - i) : 32'h0;
      check(32'(chanConn), x, "channel switch");
    end
  endtask

  task automatic t_refs();
    logic [31:0] v, r;
    wr(ADDR_BANDG, 32'h1 << BGEN_BIT, 4'h1);
    repeat (20) @(posedge clk);
    check(32'(bgEn), 32'h1, "bandgap enable");
    for (int i = 0; i < 16; i++) begin
      v = 32'(i & 3) | (32'(i & 3) << REFSEL_LSB) | (32'((i >> 2) & 1) << AMPIN_BIT)
          | (32'((i >> 3) & 1) << AMPEN_BIT);
      wr(ADDR_CTRL2, v, 4'h1);
      settle();
      rd(ADDR_CTRL2, r);
      check(r, v, "ctrl2 readback");
      check(32'(refRoute), (i & 2) ? 32'(REF_AMP) : 32'(i & 3), "ref route");
      check(32'(refPin), 32'((i & 3) == 1), "ref pin");
      check(32'(ampEn), 32'(i >> 3), "amp enable");
      check(32'(gainOut), (i >> 3) ? 32'(i & 3) : 32'h0, "gain");
      check(32'(ampPin), 32'(i == 8 || i == 9 || i == 10 || i == 11), "amp pin");
      check(32'(ampBg), 32'(i >= 12), "amp bandgap");
    end
  endtask

  task automatic t_pins();
    @(posedge clk);
    selHi <= 16'hF0F0;
    selLo <= 16'hFF00;
    dirOut <= 16'hAAAA;
    pullEn <= 16'hFFFF;
    settle();
    check(32'(digEn), 32'h0FFF, "digital enable");
    check(32'(dirEff), 32'h0AAA, "direction");
    check(32'(pullEff), 32'h0FFF, "pull-up");
  endtask

  task automatic t_conv(input int div);
    logic [31:0] r;
    int          n, ticks, samples;
    wr(ADDR_CTRL1, 32'(div) << DIV_LSB, 4'h1);
    wr(ADDR_CTRL0, EN | IE | (32'h1 << START_BIT), 4'h1);
    wr(ADDR_CTRL0, EN | IE, 4'h1);
    if (div == 0) begin
      rd(ADDR_CTRL0, r);
      check(32'(r[BUSY_BIT]), 32'h1, "busy during");
    end
    ticks = 0;
    samples = 0;
    for (n = 1; n < 3000; n++) begin
      @(posedge clk);
      if (clkEn === 1'b1) ticks++;
      if (sampling === 1'b1) samples++;
      if (done === 1'b1) break;
    end
    if (n == 3000) timeout();
    if (div != 0) begin
      check(32'(n), 32'(16 << div), "conversion length");
      check(32'(ticks), 32'h10, "converter clocks");
      check(32'(samples), 32'(4 << div), "sampling length");
    end
    settle();
    rd(ADDR_CTRL0, r);
    check(32'(r[BUSY_BIT]), 32'h0, "busy after");
    check(32'(r[IRQF_BIT]), 32'h1, "irq flag");
    check(32'(irq), 32'h1, "irq line");
    wr(ADDR_CTRL0, EN, 4'h1);
    settle();
    check(32'(irq), 32'h0, "irq masked");
    wr(ADDR_CTRL0, EN | IE | (32'h1 << IRQF_BIT), 4'h3);
    settle();
    rd(ADDR_CTRL0, r);
    check(32'(r[IRQF_BIT]), 32'h0, "irq flag cleared");
    check(32'(irq), 32'h0, "irq line cleared");
  endtask

  // conversion with the interrupt masked, end found by polling busy
  task automatic t_poll();
    logic [31:0] r;
    int          n;
    wr(ADDR_CTRL1, 32'h3 << DIV_LSB, 4'h1);
    wr(ADDR_CTRL0, EN | (32'h1 << START_BIT), 4'h1);
    wr(ADDR_CTRL0, EN, 4'h1);
    for (n = 0; n < 200; n++) begin
      rd(ADDR_CTRL0, r);
      if (r[BUSY_BIT] === 1'b0) break;
    end
    if (n == 200) timeout();
    check(32'(n > 0), 32'h1, "busy polled");
    check(32'(r[IRQF_BIT]), 32'h1, "polled irq flag");
    check(32'(irq), 32'h0, "irq disabled");
    wr(ADDR_CTRL0, EN | (32'h1 << IRQF_BIT), 4'h3);
  endtask

  task automatic t_off();
    logic [31:0] r;
    int          seen;
    wr(ADDR_CTRL0, 32'h0, 4'h1);
    settle();
    check(32'(power), 32'h0, "power off");
    wr(ADDR_CTRL0, 32'h1 << START_BIT, 4'h1);
    wr(ADDR_CTRL0, 32'h0, 4'h1);
    seen = 0;
    repeat (40) begin
      @(posedge clk);
      if (done !== 1'b0) seen++;
    end
    rd(ADDR_CTRL0, r);
    check(32'(r[BUSY_BIT]), 32'h0, "busy off");
    check(32'(seen), 32'h0, "done off");
  endtask

  initial begin
    logic [31:0] r;
    rst = 1'b1;
    {awAddr, wStrb, arAddr, wData} = '0;
    {awValid, wValid, bReady, arValid, rReady} = '0;
    {selHi, selLo, dirOut, pullEn} = '0;
    repeat (20) @(posedge clk);
    check(32'(digEn), 32'hFFFF, "reset digital enable");
    rst <= 1'b0;
    rd(ADDR_CTRL0, r);
    check(r, REG_RESET, "ctrl0 reset");
    rd(ADDR_CTRL2, r);
    check(r, REG_RESET, "ctrl2 reset");
    t_routes();
    t_refs();
    t_pins();
    wr(ADDR_CTRL0, EN, 4'h1);
    settle();
    check(32'(power), 32'h1, "power on");
    repeat (20) @(posedge clk);
    t_conv(0);
    t_conv(3);
    t_conv(7);
    t_poll();
    t_off();
    summarize();
  end

  initial begin
    #9000000;
    timeout();
  end
endmodule
